/* File: common/sxs_pkg.sv */
// sxs_pkg: opcodes, widths and constants for the subtract/xor/swap/sleep
// datapath. assumes a decoder delivers one opcode per instruction cycle.
// Behaviour
// [RQ1] sleep halts execution, stops oscillator until wake
// [RQ2] sleep clears watchdog counter and prescaler
// [RQ3] sleep clears powerdown flag, sets timeout flag
// [RQ4] subtract accumulator from register, select destination
// [RQ5] borrow flags clear when accumulator exceeds operand
// [RQ6] subtract with borrow uses inverted borrow flag
// [RQ7] nibble exchange writes swapped nibbles, no flags
// [RQ8] xor immediate into accumulator, zero flag only
// [RQ9] xor register into destination, zero flag only
// [RQ10] direction load copies accumulator to port 5-7
// [RQ11] subtract accumulator from immediate into accumulator
// [RQ12] zero flag set when result is all zero
package sxs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int WDT_W  = 8;
  localparam int PRE_W  = 8;
  localparam int NIB    = 4;

  typedef enum logic [2:0] {
    SXS_OP_NONE     = 3'b000,
    SXS_OP_SUBREG   = 3'b001,
    SXS_OP_SUBBRW   = 3'b010,
    SXS_OP_SUBIMM   = 3'b011,
    SXS_OP_SWAP     = 3'b100,
    SXS_OP_XORIMM   = 3'b101,
    SXS_OP_XORREG   = 3'b110,
    SXS_OP_SLEEP    = 3'b111
  } sxs_op_e;

  // direction load is a separate strobe so it needs no opcode slot of its own
  localparam logic [2:0] DIR_SEL_A = 3'h5;
  localparam logic [2:0] DIR_SEL_B = 3'h6;
  localparam logic [2:0] DIR_SEL_C = 3'h7;

  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RST = 8'hFF;
  localparam logic [WDT_W-1:0]  WDT_CLR = 8'h00;
  localparam logic [PRE_W-1:0]  PRE_CLR = 8'h00;
  localparam logic [DATA_W-1:0] ZERO8   = 8'h00;
endpackage

/* File: core/sxs_exec.sv */
// sxs_exec: executes one instruction per valid cycle on the core clock.
// assumes the register file supplies reg_data_in for reg_addr_in in the
// same cycle and takes the write-back strobe one cycle later.
`timescale 1ns/100ps
module sxs_exec
  import sxs_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              op_valid_in,
  input  wire logic [2:0]        op_code_in,
  input  wire logic              dir_load_in,
  input  wire logic [2:0]        dir_sel_in,
  input  wire logic              target_select_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_data_in,
  input  wire logic [DATA_W-1:0] imm_in,
  input  wire logic              wake_in,
  input  wire logic              wdt_tick_in,
  output logic [DATA_W-1:0]      acc_out,
  output logic                   reg_we_out,
  output logic [ADDR_W-1:0]      reg_waddr_out,
  output logic [DATA_W-1:0]      reg_wdata_out,
  output logic                   borrow_inverse_bit_out,
  output logic                   low_nibble_borrow_bit_out,
  output logic                   result_null_bit_out,
  output logic                   sleep_entered_flag_n_out,
  output logic                   timeout_flag_out,
  output logic                   sleeping_out,
  output logic                   osc_run_out,
  output logic [WDT_W-1:0]       watchdog_counter_out,
  output logic [DATA_W-1:0]      port_a_direction_out,
  output logic [DATA_W-1:0]      port_b_direction_out,
  output logic [DATA_W-1:0]      port_c_direction_out
);
  logic [DATA_W-1:0] acc_ff, res;
  logic              c_ff, dc_ff, z_ff, pd_n_ff, to_ff, sleep_ff;
  logic [WDT_W-1:0]  wdt_ff;
  logic [PRE_W-1:0]  pre_ff;
  logic [DATA_W-1:0] dir_a_ff, dir_b_ff, dir_c_ff;
  logic              we_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W:0]   diff;
  logic [NIB:0]      ndiff;
  logic              bin, is_sub, flag_z, to_acc, to_reg;
  logic              run;
  logic              sleep_go;
  logic              pre_wrap;
  logic              osc_ff;
  sxs_op_e           op;

  assign op  = sxs_op_e'(op_code_in);
  // nothing executes while asleep; wake is handled by the sleep entry block below
  assign run = op_valid_in && !sleep_ff; // see [RQ1]

  // sleep is taken like any other opcode; a direction load overrides it
  // because the decoder raises dir_load_in with a don't-care opcode
  assign sleep_go = run && (op == SXS_OP_SLEEP) && !dir_load_in;

  // prescaler overflow carries one count into the watchdog; the counter
  // itself wraps silently, the time-out reaction lives outside this block
  assign pre_wrap = wdt_tick_in && (pre_ff == {PRE_W{1'b1}});

  // shared subtractor: operand minus accumulator minus borrow
  always_comb begin
    opnd   = (op == SXS_OP_SUBIMM || op == SXS_OP_XORIMM) ? imm_in
                                                          : reg_data_in;
    bin    = (op == SXS_OP_SUBBRW) ? ~c_ff : 1'b0; // see [RQ6]
    // borrow out of bit 8 / bit 4 gives inverted carry flags
    diff   = {1'b0, opnd} - {1'b0, acc_ff} - {{DATA_W{1'b0}}, bin};
    ndiff  = {1'b0, opnd[NIB-1:0]} - {1'b0, acc_ff[NIB-1:0]}
             - {{NIB{1'b0}}, bin};
    is_sub = 1'b0;
    flag_z = 1'b0;
    to_acc = 1'b0;
    to_reg = 1'b0;
    res    = ZERO8;
    unique case (op)
      SXS_OP_SUBREG, SXS_OP_SUBBRW: begin // see [RQ4] see [RQ6]
        res = diff[DATA_W-1:0];
        is_sub = 1'b1;
        flag_z = 1'b1;
        to_acc = !target_select_in;
        to_reg = target_select_in;
      end
      SXS_OP_SUBIMM: begin // see [RQ11]
        res = diff[DATA_W-1:0];
        is_sub = 1'b1;
        flag_z = 1'b1;
        to_acc = 1'b1;
      end
      SXS_OP_SWAP: begin // see [RQ7]
        res = {opnd[NIB-1:0], opnd[DATA_W-1:NIB]};
        to_acc = !target_select_in;
        to_reg = target_select_in;
      end
      SXS_OP_XORIMM: begin // see [RQ8]
        res = acc_ff ^ opnd;
        flag_z = 1'b1;
        to_acc = 1'b1;
      end
      SXS_OP_XORREG: begin // see [RQ9]
        res = acc_ff ^ opnd;
        flag_z = 1'b1;
        to_acc = !target_select_in;
        to_reg = target_select_in;
      end
      SXS_OP_NONE, SXS_OP_SLEEP: begin
        res = ZERO8;
      end
    endcase
  end

  // accumulator write-back
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      acc_ff <= ACC_RST;
    end else if (run && to_acc && !dir_load_in) begin
      acc_ff <= res;
    end
  end

  // register file write-back, one-cycle strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      we_ff    <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= ZERO8;
    end else begin
      we_ff <= run && to_reg && !dir_load_in;
      if (run && to_reg) begin
        waddr_ff <= reg_addr_in;
        wdata_ff <= res;
      end
    end
  end

  // arithmetic flags; only instructions that touch them update them
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      c_ff  <= 1'b0;
      dc_ff <= 1'b0;
      z_ff  <= 1'b0;
    end else if (run && !dir_load_in) begin
      if (is_sub) begin
        c_ff  <= ~diff[DATA_W]; // see [RQ5]
        dc_ff <= ~ndiff[NIB];   // see [RQ5]
      end
      if (flag_z) begin
        z_ff <= (res == ZERO8); // see [RQ12]
      end
    end
  end

  // sleep entry and power status; wake simply releases the halt.
  // the oscillator-run output is its own flop so that it leaves the
  // block glitch-free, at the cost of one more register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sleep_ff <= 1'b0;
      osc_ff   <= 1'b1;
      pd_n_ff  <= 1'b1;
      to_ff    <= 1'b1;
    end else if (sleep_go) begin
      sleep_ff <= 1'b1; // see [RQ1]
      osc_ff   <= 1'b0; // see [RQ1]
      pd_n_ff  <= 1'b0; // see [RQ3]
      to_ff    <= 1'b1; // see [RQ3]
    end else if (sleep_ff && wake_in) begin
      sleep_ff <= 1'b0;
      osc_ff   <= 1'b1;
    end
  end

  // watchdog and prescaler: cleared by sleep, clear wins over the tick
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wdt_ff <= WDT_CLR;
      pre_ff <= PRE_CLR;
    end else if (sleep_go) begin
      wdt_ff <= WDT_CLR; // see [RQ2]
      pre_ff <= PRE_CLR; // see [RQ2]
    end else if (wdt_tick_in) begin
      pre_ff <= pre_ff + 1'b1;
      if (pre_wrap) begin
        wdt_ff <= wdt_ff + 1'b1;
      end
    end
  end

  // direction registers; other selector values are ignored
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      dir_a_ff <= DIR_RST;
      dir_b_ff <= DIR_RST;
      dir_c_ff <= DIR_RST;
    end else if (op_valid_in && !sleep_ff && dir_load_in) begin
      if (dir_sel_in == DIR_SEL_A) dir_a_ff <= acc_ff; // see [RQ10]
      if (dir_sel_in == DIR_SEL_B) dir_b_ff <= acc_ff; // see [RQ10]
      if (dir_sel_in == DIR_SEL_C) dir_c_ff <= acc_ff; // see [RQ10]
    end
  end

  assign acc_out                   = acc_ff;
  assign reg_we_out                = we_ff;
  assign reg_waddr_out             = waddr_ff;
  assign reg_wdata_out             = wdata_ff;
  assign borrow_inverse_bit_out    = c_ff;
  assign low_nibble_borrow_bit_out = dc_ff;
  assign result_null_bit_out       = z_ff;
  assign sleep_entered_flag_n_out  = pd_n_ff;
  assign timeout_flag_out          = to_ff;
  assign sleeping_out              = sleep_ff;
  assign osc_run_out               = osc_ff; // see [RQ1]
  assign watchdog_counter_out      = wdt_ff;
  assign port_a_direction_out      = dir_a_ff;
  assign port_b_direction_out      = dir_b_ff;
  assign port_c_direction_out      = dir_c_ff;
endmodule

/* File: tb/sxs_exec_chk.sv */
// sxs_exec_chk: port-level property checks for the exec datapath.
// assumes one clock domain and binding onto every sxs_exec instance.
`timescale 1ns/100ps
module sxs_exec_chk
  import sxs_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic       dir_load_in,
  input wire logic [2:0] dir_sel_in,
  input wire logic       target_select_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic [7:0] reg_data_in,
  input wire logic [7:0] imm_in,
  input wire logic       wake_in,
  input wire logic [7:0] acc_out,
  input wire logic       reg_we_out,
  input wire logic [6:0] reg_waddr_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic       borrow_inverse_bit_out,
  input wire logic       low_nibble_borrow_bit_out,
  input wire logic       result_null_bit_out,
  input wire logic       sleep_entered_flag_n_out,
  input wire logic       timeout_flag_out,
  input wire logic       sleeping_out,
  input wire logic [7:0] watchdog_counter_out,
  input wire logic [7:0] port_a_direction_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // an opcode is taken only when awake and not a direction load
  wire go = op_valid_in & ~sleeping_out & ~dir_load_in;
  sequence s_take_sleep;
    go && op_code_in == SXS_OP_SLEEP;
  endsequence
  sequence s_asleep;
    sleeping_out && !sleep_entered_flag_n_out && timeout_flag_out;
  endsequence
  a_sleep_entry: assert property (
    s_take_sleep |=> s_asleep ##0 watchdog_counter_out == WDT_CLR)
    else $error("bad sleep");
  a_sleep_hold: assert property (
    sleeping_out && !wake_in |=> $stable(acc_out))
    else $error("acc moved asleep");
  a_xor_imm: assert property (
    go && op_code_in == SXS_OP_XORIMM |=>
    acc_out == ($past(acc_out) ^ $past(imm_in))) else $error("bad xor");
  a_swap_write: assert property (
    go && op_code_in == SXS_OP_SWAP && target_select_in |=>
    reg_we_out && $stable(result_null_bit_out)
    && reg_waddr_out == $past(reg_addr_in) && reg_wdata_out ==
    {$past(reg_data_in[3:0]), $past(reg_data_in[7:4])})
    else $error("swap");
  a_sub_acc: assert property (
    go && op_code_in == SXS_OP_SUBREG && !target_select_in |=>
    acc_out == 8'($past(reg_data_in) - $past(acc_out)))
    else $error("bad sub");
  a_borrow_flag: assert property (
    go && op_code_in == SXS_OP_SUBREG |=>
    borrow_inverse_bit_out == ($past(acc_out) <= $past(reg_data_in)))
    else $error("bad borrow");
  a_nibble_flag: assert property (
    go && op_code_in == SXS_OP_SUBREG |=>
    low_nibble_borrow_bit_out ==
    ($past(acc_out[3:0]) <= $past(reg_data_in[3:0])))
    else $error("bad nibble borrow");
  a_zero_flag: assert property (
    go && !target_select_in
    && op_code_in inside {SXS_OP_XORIMM, SXS_OP_XORREG} |=>
    result_null_bit_out == (acc_out == ZERO8)) else $error("bad zero");
  a_dir_load: assert property (
    op_valid_in && !sleeping_out && dir_load_in
    && dir_sel_in == DIR_SEL_A |=> port_a_direction_out == $past(acc_out))
    else $error("bad dir");
endmodule

bind sxs_exec sxs_exec_chk u_chk (.*);

/* File: tb/sxs_exec_test.sv */
// sxs_exec_test: random self-checking bench with a reference model.
// assumes one clock; inputs change at the falling edge.
`timescale 1ns/100ps
module sxs_exec_test;
  import sxs_pkg::*;
  logic       clk = 0, rst = 1, v = 0, dl = 0, ts = 0, wk = 0, tk = 0;
  logic [2:0] op = 0, ds = 0;
  logic [6:0] ad = 0, wa;
  logic [7:0] rd = 0, k = 0, ea = 0, acc, wd, pa, pb, pc, wc;
  logic [7:0] ed [3] = '{default: 8'hFF};
  logic       we, c, dc, z, pd, to, sl, osc, ec = 0, edc = 0, ez = 0, ewe = 0;
  logic [8:0] r = 0;
  logic [4:0] n;
  int         n_mismatch = 0, tests_run = 0, i;
  sxs_exec uut (.ref_clk_in(clk), .rst_in(rst), .op_valid_in(v),
    .op_code_in(op), .dir_load_in(dl), .dir_sel_in(ds),
    .target_select_in(ts), .reg_addr_in(ad), .reg_data_in(rd), .imm_in(k),
    .wake_in(wk), .wdt_tick_in(tk), .acc_out(acc), .reg_we_out(we),
    .reg_waddr_out(wa), .reg_wdata_out(wd), .borrow_inverse_bit_out(c),
    .low_nibble_borrow_bit_out(dc), .result_null_bit_out(z),
    .sleep_entered_flag_n_out(pd), .timeout_flag_out(to), .sleeping_out(sl),
    .osc_run_out(osc), .watchdog_counter_out(wc), .port_a_direction_out(pa),
    .port_b_direction_out(pb), .port_c_direction_out(pc));
  // free-running core clock
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("mismatches=%0d compares=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // compare ports against the model; run before inputs change
  task automatic cmp;
    chk(acc, ea);
    chk({5'h00, c, dc, z}, {5'h00, ec, edc, ez});
    chk({7'h00, we}, {7'h00, ewe});
    if (ewe) chk({1'b0, wa}, {1'b0, ad});
    if (ewe) chk(wd, r[7:0]);
    chk(pa, ed[0]);
    chk(pb, ed[1]);
    chk(pc, ed[2]);
  endtask
  // reference model of one taken instruction
  task automatic model;
    logic [7:0] x;
    logic       b;
    x = (op == 3'h3) ? k : rd;
    b = (op == 3'h2) & ~ec;
    ewe = 0;
    if (dl) begin
      if (ds > 3'h4) ed[ds - 3'h5] = ea;
    end else begin
      r = {1'b0, x} - {1'b0, ea} - b;
      n = {1'b0, x[3:0]} - {1'b0, ea[3:0]} - b;
      if (op == 3'h4) r = {1'b0, rd[3:0], rd[7:4]};
      if (op == 3'h5) r = {1'b0, ea ^ k};
      if (op == 3'h6) r = {1'b0, ea ^ rd};
      if (op < 3'h4) {ec, edc} = {~r[8], ~n[4]};
      if (op != 3'h4) ez = (r[7:0] == 8'h00);
      if (ts && op inside {3'h1, 3'h2, 3'h4, 3'h6}) ewe = 1;
      else ea = r[7:0];
    end
  endtask
  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    results;
  end
  initial begin
    void'($urandom(32'h124CD50E));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 0;
    tk = 1;
    chk({4'h0, pd, to, sl, osc}, 8'h0D);
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      cmp;
      v = 1;
      dl = ($urandom % 8 == 0);
      ds = 3'($urandom);
      op = 3'(1 + $urandom % 6);
      ts = 1'($urandom);
      ad = 7'($urandom);
      rd = ($urandom % 6 == 0) ? ea : 8'($urandom);
      k = ($urandom % 6 == 0) ? ea : 8'($urandom);
      model;
    end
    @(negedge clk);
    cmp;
    dl = 0;
    op = SXS_OP_SLEEP;
    @(negedge clk);
    chk({4'h0, pd, to, sl, osc}, 8'h06);
    chk(wc, WDT_CLR);
    op = SXS_OP_XORIMM;
    k = 8'hFF;
    repeat (3) @(negedge clk);
    chk(acc, ea);
    v = 0;
    wk = 1;
    for (i = 0; i < 10 && sl; i++) @(negedge clk);
    chk({7'h00, sl}, 8'h00);
    results;
  end
endmodule
